// ==== src/packet_start_indicator.sv ====
// packet start indicator: apb registers and both detection paths
`timescale 1ns/1ps
`default_nettype none
module packet_start_indicator (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // apb slave
   input wire logic [19:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // link state
   input wire logic link_speed_100,
   // transmit stream, mac side and fifo output
   input wire logic tx_fifo_bypass,
   input wire logic mac_tx_en,
   input wire packet_start_pkg::nibble_t mac_txd,
   input wire logic fifo_tx_en,
   input wire packet_start_pkg::nibble_t fifo_txd,
   // receive stream
   input wire logic rx_dv,
   input wire packet_start_pkg::nibble_t rxd,
   // indications and fifo mode
   output logic tx_packet_start_indication,
   output logic rx_packet_start_indication,
   output logic tx_fifo_sync_enable
);
   import packet_start_pkg::*;

   logic [15:0] tx_fifo_sync_mode;
   logic [15:0] packet_start_control;
   logic [15:0] packet_start_rx_delay;
   logic [15:0] packet_start_tx_delay;
   logic [31:0] rd_value;

   // address decode; misaligned addresses miss
   wire aligned = paddr[1:0] == 2'b00;
   wire index_t idx = paddr[19:2];
   wire sel_sync = aligned && idx == IDX_SYNC;
   wire sel_ctrl = aligned && idx == IDX_CTRL;
   wire sel_rxdel = aligned && idx == IDX_RXDEL;
   wire sel_txdel = aligned && idx == IDX_TXDEL;
   wire hit = sel_sync || sel_ctrl || sel_rxdel || sel_txdel;

   // one wait state: first access cycle prepares, second completes
   wire access = psel && penable;
   wire prepare = access && !pready;
   wire done = access && pready;
   wire wr = done && pwrite && hit;

   // read selection, upper half always zero
   assign rd_value = sel_sync ? {16'h0000, tx_fifo_sync_mode} :
                     sel_ctrl ? {16'h0000, packet_start_control} :
                     sel_rxdel ? {16'h0000, packet_start_rx_delay} :
                     sel_txdel ? {16'h0000, packet_start_tx_delay} :
                     32'h00000000;

   // bus answer registers; data and error ready with pready
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else begin
         pready <= prepare;
         pslverr <= prepare && !hit;
         if (prepare) begin
            prdata <= pwrite ? 32'h00000000 : rd_value;
         end
      end
   end

   // register writes take effect only at the completing edge
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_fifo_sync_mode <= RST_SYNC;
         packet_start_control <= RST_CTRL;
         packet_start_rx_delay <= RST_RXDEL;
         packet_start_tx_delay <= RST_TXDEL;
      end else if (wr) begin
         if (sel_sync) begin
            tx_fifo_sync_mode <= merge16(tx_fifo_sync_mode, pwdata[15:0], pstrb[1:0]) & MASK_SYNC;
         end
         if (sel_ctrl) begin
            packet_start_control <=
               merge16(packet_start_control, pwdata[15:0], pstrb[1:0]) & MASK_CTRL;
         end
         if (sel_rxdel) begin
            packet_start_rx_delay <=
               merge16(packet_start_rx_delay, pwdata[15:0], pstrb[1:0]) & MASK_RXDEL;
         end
         if (sel_txdel) begin
            packet_start_tx_delay <=
               merge16(packet_start_tx_delay, pwdata[15:0], pstrb[1:0]) & MASK_TXDEL;
         end
      end
   end

   // fifo mode output registered from its register bit, one cycle later
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_fifo_sync_enable <= 1'b0;
      end else begin
         tx_fifo_sync_enable <= tx_fifo_sync_mode[SYNC_BIT];
      end
   end

   // control fields
   wire tx_indication_enable = packet_start_control[TX_EN_BIT];
   wire rx_indication_enable = packet_start_control[RX_EN_BIT];
   wire delimiter_detect_enable = packet_start_control[SFD_EN_BIT];
   wire fixed_length_enable = packet_start_control[FIXED_BIT];
   wire [2:0] indication_length_field = packet_start_control[LEN_MSB:LEN_LSB];
   wire len_t hold_len = len_cycles(indication_length_field);

   // receive delay picked by link speed
   wire [4:0] rx_delay_10m_cycles = packet_start_rx_delay[RX10_MSB:RX10_LSB];
   wire [4:0] rx_delay_100m_cycles = packet_start_rx_delay[RX100_MSB:RX100_LSB];
   wire [4:0] rx_delay_now = link_speed_100 ? rx_delay_100m_cycles : rx_delay_10m_cycles;
   wire delay_t rx_delay = {1'b0, rx_delay_now};

   // transmit delay: 8 ns units rounded up to whole cycles
   wire [4:0] tx_delay_10m = packet_start_tx_delay[TX10_MSB:TX10_LSB];
   wire [3:0] tx_delay_100m = packet_start_tx_delay[TX100_MSB:TX100_LSB];
   wire [4:0] tx_delay_now = link_speed_100 ? {1'b0, tx_delay_100m} : tx_delay_10m;
   wire delay_t tx_delay = tx_cycles(tx_delay_now);

   // fifo output watched when fifo is in the path, less jitter
   wire tx_active = tx_fifo_bypass ? mac_tx_en : fifo_tx_en;
   wire nibble_t tx_nibble = tx_fifo_bypass ? mac_txd : fifo_txd;

   // transmit path
   packet_start_path tx_path (
      .clock(clock),
      .resetn(resetn),
      .enable(tx_indication_enable),
      .sfd_en(delimiter_detect_enable),
      .fixed_len(fixed_length_enable),
      .len(hold_len),
      .delay(tx_delay),
      .active(tx_active),
      .nibble(tx_nibble),
      .indication(tx_packet_start_indication)
   );

   // receive path
   packet_start_path rx_path (
      .clock(clock),
      .resetn(resetn),
      .enable(rx_indication_enable),
      .sfd_en(delimiter_detect_enable),
      .fixed_len(fixed_length_enable),
      .len(hold_len),
      .delay(rx_delay),
      .active(rx_dv),
      .nibble(rxd),
      .indication(rx_packet_start_indication)
   );

   // run length of the receive indication, checks only
   logic [7:0] rx_hi_cnt;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rx_hi_cnt <= 8'h00;
      end else if (rx_packet_start_indication) begin
         rx_hi_cnt <= rx_hi_cnt + 8'h01;
      end else begin
         rx_hi_cnt <= 8'h00;
      end
   end

   // run length of the transmit indication, checks only
   logic [7:0] tx_hi_cnt;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         tx_hi_cnt <= 8'h00;
      end else if (tx_packet_start_indication) begin
         tx_hi_cnt <= tx_hi_cnt + 8'h01;
      end else begin
         tx_hi_cnt <= 8'h00;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!resetn);

   // disabled transmit path stays quiet
   property p_tx_off;
      !tx_indication_enable |=> !tx_packet_start_indication;
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("tx indication while disabled");

   // disabled receive path stays quiet
   property p_rx_off;
      !rx_indication_enable |=> !rx_packet_start_indication;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("rx indication while disabled");

   // delimiter mode ignores the first nibble
   property p_sfd_wait;
      delimiter_detect_enable && $rose(rx_dv) && !$past(rx_packet_start_indication)
         |=> !rx_packet_start_indication;
   endproperty
   a_sfd_wait: assert property (p_sfd_wait) else $error("rx fired before delimiter");

   // delimiter recognised with no delay raises indication next cycle
   property p_sfd_fire;
      rx_indication_enable && delimiter_detect_enable && rx_delay == DELAY_NONE &&
      rx_dv && $past(rx_dv) && rxd == SFD_HI && $past(rxd) == SFD_LO &&
      !rx_packet_start_indication && !$past(rx_packet_start_indication)
         |=> rx_packet_start_indication;
   endproperty
   a_sfd_fire: assert property (p_sfd_fire) else $error("rx missed delimiter");

   // delimiter on the transmit stream, no delay
   property p_tx_sfd;
      tx_indication_enable && delimiter_detect_enable && tx_delay == DELAY_NONE &&
      tx_active && $past(tx_active) && tx_nibble == SFD_HI && $past(tx_nibble) == SFD_LO &&
      !tx_packet_start_indication && !$past(tx_packet_start_indication)
         |=> tx_packet_start_indication;
   endproperty
   a_tx_sfd: assert property (p_tx_sfd) else $error("tx missed delimiter");

   // first nibble mode with no delay
   property p_first;
      rx_indication_enable && !delimiter_detect_enable && rx_delay == DELAY_NONE &&
      $rose(rx_dv) |=> rx_packet_start_indication;
   endproperty
   a_first: assert property (p_first) else $error("rx missed first nibble");

   // whole-frame mode holds while the frame lasts
   property p_whole;
      rx_packet_start_indication && !fixed_length_enable && rx_indication_enable && rx_dv
         |=> rx_packet_start_indication;
   endproperty
   a_whole: assert property (p_whole) else $error("rx dropped inside frame");

   // same for the transmit side
   property p_tx_whole;
      tx_packet_start_indication && !fixed_length_enable && tx_indication_enable && tx_active
         |=> tx_packet_start_indication;
   endproperty
   a_tx_whole: assert property (p_tx_whole) else $error("tx dropped inside frame");

   // fixed mode never exceeds (n+1)*8 cycles
   property p_len;
      fixed_length_enable |-> rx_hi_cnt <= {1'b0, hold_len};
   endproperty
   a_len: assert property (p_len) else $error("rx held too long");

   // same bound on the transmit side
   property p_tx_len;
      fixed_length_enable |-> tx_hi_cnt <= {1'b0, hold_len};
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("tx held too long");

   // fixed mode drops right after the last counted cycle
   property p_rx_exact;
      fixed_length_enable && rx_indication_enable && rx_dv && rx_packet_start_indication &&
      rx_hi_cnt == {1'b0, hold_len} - 8'h01 |=> !rx_packet_start_indication;
   endproperty
   a_rx_exact: assert property (p_rx_exact) else $error("rx fixed length wrong");

   // end of frame always drops the indications
   property p_end;
      !rx_dv && !tx_active |=> !rx_packet_start_indication && !tx_packet_start_indication;
   endproperty
   a_end: assert property (p_end) else $error("indication past frame end");

   // transmit start taken at fifo output when fifo is used
   property p_fifo;
      !tx_fifo_bypass && tx_indication_enable && !delimiter_detect_enable &&
      tx_delay == DELAY_NONE && $rose(fifo_tx_en) |=> tx_packet_start_indication;
   endproperty
   a_fifo: assert property (p_fifo) else $error("tx missed fifo start");

   // 10M receive delay of two cycles
   property p_rx10;
      (rx_indication_enable && !delimiter_detect_enable && !link_speed_100 &&
       rx_delay_10m_cycles == 5'h02 && $rose(rx_dv))
      ##1 (rx_dv && rx_indication_enable && !link_speed_100)[*2]
         |-> !rx_packet_start_indication ##1 rx_packet_start_indication;
   endproperty
   a_rx10: assert property (p_rx10) else $error("10M rx delay wrong");

   // 100M receive delay of two cycles
   property p_rx100;
      (rx_indication_enable && !delimiter_detect_enable && link_speed_100 &&
       rx_delay_100m_cycles == 5'h02 && $rose(rx_dv))
      ##1 (rx_dv && rx_indication_enable && link_speed_100)[*2]
         |-> !rx_packet_start_indication ##1 rx_packet_start_indication;
   endproperty
   a_rx100: assert property (p_rx100) else $error("100M rx delay wrong");

   // sync bit reaches the fifo two edges after the write
   property p_sync;
      wr && sel_sync && pstrb[0] |=> ##1 tx_fifo_sync_enable == $past(pwdata[SYNC_BIT], 2);
   endproperty
   a_sync: assert property (p_sync) else $error("fifo sync mode not applied");

   // 10M transmit delay of five units is one cycle
   property p_tx10;
      (tx_indication_enable && !delimiter_detect_enable && !link_speed_100 &&
       tx_fifo_bypass && tx_delay_10m == 5'h05 && $rose(mac_tx_en))
      ##1 (mac_tx_en && tx_fifo_bypass && tx_indication_enable && !link_speed_100)
         |-> !tx_packet_start_indication ##1 tx_packet_start_indication;
   endproperty
   a_tx10: assert property (p_tx10) else $error("10M tx delay wrong");

   // disabled transmit path drops any pending delay and trigger
   property p_tx_discard;
      !tx_indication_enable |=> !tx_path.waiting && !tx_path.armed;
   endproperty
   a_tx_discard: assert property (p_tx_discard) else $error("tx count kept");

   // disabled receive path drops any pending delay and trigger
   property p_rx_discard;
      !rx_indication_enable |=> !rx_path.waiting && !rx_path.armed;
   endproperty
   a_rx_discard: assert property (p_rx_discard) else $error("rx count kept");

   // control register holds its default on leaving reset
   property p_rst_ctrl;
      $rose(resetn) |-> packet_start_control == RST_CTRL;
   endproperty
   a_rst_ctrl: assert property (p_rst_ctrl) else $error("control reset value wrong");

   // bus answer lasts exactly one cycle
   property p_answer;
      pready |=> !pready && !pslverr;
   endproperty
   a_answer: assert property (p_answer) else $error("bus answer held too long");

   // main scenarios
   c_rx_sfd: cover property (delimiter_detect_enable && $rose(rx_packet_start_indication));
   c_tx_fixed: cover property (fixed_length_enable && tx_active &&
                               $fell(tx_packet_start_indication));
   c_rx_delayed: cover property (rx_delay != DELAY_NONE && $rose(rx_packet_start_indication));
   c_bad_addr: cover property (done && pslverr);
   c_rx_first: cover property (!delimiter_detect_enable && $rose(rx_packet_start_indication));

endmodule
`default_nettype wire

// ==== src/packet_start_pkg.sv ====
// constants, types and helpers for the packet start indicator
// Functional notes
// - tx indications only while tx enable set
// - rx indications only while rx enable set
// - delimiter mode: assert on start-frame delimiter
// - otherwise assert on first frame nibble
// - whole-frame mode holds indication all frame
// - fixed mode holds (N+1)*8 clock cycles
// - indication always drops at frame end
// - tx start taken at fifo output, at mac side when fifo bypassed
// - 10M rx delay from field 15:11
// - 100M rx delay from field 10:6
// - sync bit runs tx fifo synchronously
// - control register resets to 0x0034
// - tx delay in 8 ns units per speed
package packet_start_pkg;

   typedef logic [5:0] delay_t;
   typedef logic [6:0] len_t;
   typedef logic [3:0] nibble_t;
   typedef logic [17:0] index_t;

   // register indices; byte address is four times the index
   localparam index_t IDX_SYNC = 18'h09427;
   localparam index_t IDX_CTRL = 18'h09428;
   localparam index_t IDX_RXDEL = 18'h09429;
   localparam index_t IDX_TXDEL = 18'h0942a;

   // reset values and writable masks
   localparam logic [15:0] RST_SYNC = 16'h0000;
   localparam logic [15:0] RST_CTRL = 16'h0034;
   localparam logic [15:0] RST_RXDEL = 16'h0000;
   localparam logic [15:0] RST_TXDEL = 16'h0000;
   localparam logic [15:0] MASK_SYNC = 16'h0001;
   localparam logic [15:0] MASK_CTRL = 16'h007f;
   localparam logic [15:0] MASK_RXDEL = 16'hffff;
   localparam logic [15:0] MASK_TXDEL = 16'h1fff;

   // field positions
   localparam int SYNC_BIT = 0;
   localparam int TX_EN_BIT = 0;
   localparam int RX_EN_BIT = 1;
   localparam int SFD_EN_BIT = 2;
   localparam int FIXED_BIT = 3;
   localparam int LEN_LSB = 4;
   localparam int LEN_MSB = 6;
   localparam int RX10_LSB = 11;
   localparam int RX10_MSB = 15;
   localparam int RX100_LSB = 6;
   localparam int RX100_MSB = 10;
   localparam int TX10_LSB = 8;
   localparam int TX10_MSB = 12;
   localparam int TX100_LSB = 4;
   localparam int TX100_MSB = 7;

   // frame delimiter nibbles in wire order, and timing
   localparam nibble_t SFD_LO = 4'h5;
   localparam nibble_t SFD_HI = 4'hd;
   localparam int unsigned CLOCK_MHZ = 25;
   localparam int unsigned CLOCK_NS = 1000 / CLOCK_MHZ;
   localparam int unsigned TX_UNIT_NS = 8;
   localparam int unsigned LEN_UNIT = 8;
   localparam delay_t DELAY_NONE = 6'h00;
   localparam delay_t DELAY_LAST = 6'h01;

   // byte-lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] data,
                                           input logic [1:0] strb);
      return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
   endfunction

   // hold length of a fixed indication, (n+1)*8 cycles
   function automatic len_t len_cycles(input logic [2:0] n);
      return len_t'((int'(n) + 1) * LEN_UNIT);
   endfunction

   // 8 ns units to clock cycles, rounded up
   function automatic delay_t tx_cycles(input logic [4:0] n);
      int unsigned ns;
      ns = int'(n) * TX_UNIT_NS;
      return delay_t'((ns + CLOCK_NS - 1) / CLOCK_NS);
   endfunction

endpackage

// ==== src/packet_start_path.sv ====
// one path of packet start detection: trigger, delay and hold
`timescale 1ns/1ps
`default_nettype none
module packet_start_path (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // settings
   input wire logic enable,
   input wire logic sfd_en,
   input wire logic fixed_len,
   input wire packet_start_pkg::len_t len,
   input wire packet_start_pkg::delay_t delay,
   // frame stream
   input wire logic active,
   input wire packet_start_pkg::nibble_t nibble,
   // result
   output logic indication
);
   import packet_start_pkg::*;

   logic prev_active;
   nibble_t prev_nibble;
   logic armed;
   logic waiting;
   delay_t wait_cnt;
   len_t hold_cnt;

   // trigger selection; armed stops a second trigger in one frame
   wire first_nibble = active && !prev_active;
   wire sfd_seen = active && prev_active && nibble == SFD_HI && prev_nibble == SFD_LO;
   wire start = enable && !armed && (sfd_en ? sfd_seen : first_nibble);
   wire fire = (start && delay == DELAY_NONE) || (waiting && wait_cnt == DELAY_LAST);
   wire expire = fixed_len && hold_cnt == len_t'(1);
   wire idle = !enable || !active;

   // history of the stream, kept even while disabled
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         prev_active <= 1'b0;
         prev_nibble <= 4'h0;
      end else begin
         prev_active <= active;
         prev_nibble <= nibble;
      end
   end

   // delay, hold and drop; frame end or disable wins over all
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         armed <= 1'b0;
         waiting <= 1'b0;
         wait_cnt <= DELAY_NONE;
         hold_cnt <= len_t'(0);
         indication <= 1'b0;
      end else if (idle) begin
         armed <= 1'b0;
         waiting <= 1'b0;
         indication <= 1'b0;
      end else begin
         if (start) begin
            armed <= 1'b1;
         end
         if (start && delay != DELAY_NONE) begin
            waiting <= 1'b1;
         end else if (fire) begin
            waiting <= 1'b0;
         end
         wait_cnt <= start ? delay : wait_cnt - DELAY_LAST;
         if (fire) begin
            indication <= 1'b1;
            hold_cnt <= len;
         end else begin
            hold_cnt <= hold_cnt - len_t'(1);
            if (expire) begin
               indication <= 1'b0;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ==== dv/mii_frame_model.sv ====
// frame stream model driving all three streams: mac tx, fifo tx output and rx
`timescale 1ns/1ps
`default_nettype none
module mii_frame_model (
   // clock
   input wire logic clock,
   // streams toward the block: lane 0 mac tx, lane 1 fifo tx, lane 2 rx
   output logic [2:0] en,
   output logic [11:0] nib,
   // indications watched back
   input wire logic tx_ind,
   input wire logic rx_ind
);
   logic busy = 1'b0;

   initial begin
      en = 3'b000;
      nib = 12'h000;
   end

   // idle nibbles churn so a stale value never looks like a frame
   always @(posedge clock) begin
      if (!busy) begin
         nib <= nib + 12'h359;
      end
   end

   // one frame: preamble, delimiter at nibble p, data; then a long gap
   task automatic run(input int sel, input int len, input int p, output int rise,
                      output int width);
      logic ind;
      rise = -1;
      width = 0;
      busy = 1'b1;
      for (int i = 0; i < len + 40; i++) begin
         @(posedge clock);
         en[sel] <= (i < len);
         nib[sel*4 +: 4] <= (i < p) ? 4'h5 : (i == p) ? 4'hd : 4'ha ^ 4'(i);
         #1;
         ind = (sel == 2) ? rx_ind : tx_ind;
         if (ind === 1'b1) begin
            if (rise < 0) begin
               rise = i;
            end
            width++;
         end
      end
      busy = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== dv/packet_start_indicator_tb_top.sv ====
// self-checking bench for the packet start indicator
`timescale 1ns/1ps
`default_nettype none
module packet_start_indicator_tb_top;
   import packet_start_pkg::*;
   logic clock = 1'b0;
   logic resetn = 1'b0;
   logic [19:0] paddr = 20'h00000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic link_speed_100 = 1'b1;
   logic tx_fifo_bypass = 1'b1;
   logic [2:0] stream_en;
   logic [11:0] stream_nib;
   logic tx_ind;
   logic rx_ind;
   logic sync_en;
   int n_errors = 0;
   int n_compared = 0;
   int rise;
   int width;
   logic [31:0] rd;
   logic err;

   packet_start_indicator packet_start_indicator_inst (
      .clock(clock), .resetn(resetn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link_speed_100(link_speed_100), .tx_fifo_bypass(tx_fifo_bypass),
      .mac_tx_en(stream_en[0]), .mac_txd(stream_nib[3:0]), .fifo_tx_en(stream_en[1]),
      .fifo_txd(stream_nib[7:4]), .rx_dv(stream_en[2]), .rxd(stream_nib[11:8]),
      .tx_packet_start_indication(tx_ind), .rx_packet_start_indication(rx_ind),
      .tx_fifo_sync_enable(sync_en));

   mii_frame_model mii_frame_model_inst (
      .clock(clock), .en(stream_en), .nib(stream_nib), .tx_ind(tx_ind), .rx_ind(rx_ind));

   // free-running 25 MHz clock
   initial begin
      forever #20 clock = ~clock;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // one apb transfer; waits for pready, only the watchdog ends a hang
   task automatic apb(input logic wr, input index_t idx, input logic [15:0] wdata,
                      input logic [3:0] strb, output logic [31:0] rdata, output logic slverr);
      @(posedge clock);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {16'h0000, wdata};
      pstrb <= strb;
      @(posedge clock);
      penable <= 1'b1;
      do begin
         @(posedge clock);
      end while (pready !== 1'b1);
      rdata = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input index_t idx, input logic [15:0] d);
      apb(1'b1, idx, d, 4'h3, rd, err);
   endtask

   task automatic rdc(input index_t idx, input logic [31:0] exp, input logic experr);
      apb(1'b0, idx, 16'h0000, 4'h0, rd, err);
      chk(rd, exp, "read data");
      chk(32'(err), 32'(experr), "slave error");
   endtask

   // runs one frame on a lane and judges rise point and high time
   task automatic frame(input int sel, input int len, input int p, input int erise,
                        input int ewidth);
      mii_frame_model_inst.run(sel, len, p, rise, width);
      chk(32'(rise), 32'(erise), "indication start");
      chk(32'(width), 32'(ewidth), "indication length");
   endtask

   task automatic t_regs();
      rdc(IDX_CTRL, 32'h00000034, 1'b0);
      rdc(IDX_SYNC, 32'h00000000, 1'b0);
      rdc(IDX_RXDEL, 32'h00000000, 1'b0);
      rdc(IDX_TXDEL, 32'h00000000, 1'b0);
      wr(IDX_SYNC, 16'hffff);
      rdc(IDX_SYNC, 32'h00000001, 1'b0);
      chk(32'(sync_en), 32'h00000001, "fifo sync output");
      wr(IDX_SYNC, 16'h0000);
      wr(IDX_CTRL, 16'hff30);
      rdc(IDX_CTRL, 32'h00000030, 1'b0);
      // upper lane alone must leave the low control bits untouched
      apb(1'b1, IDX_CTRL, 16'h0004, 4'h2, rd, err);
      rdc(IDX_CTRL, 32'h00000030, 1'b0);
      wr(IDX_TXDEL, 16'hffff);
      rdc(IDX_TXDEL, 32'h00001fff, 1'b0);
      wr(IDX_TXDEL, 16'h0000);
      apb(1'b1, 18'h0942b, 16'hffff, 4'h3, rd, err);
      chk(32'(err), 32'h00000001, "unmapped write error");
      rdc(18'h0942b, 32'h00000000, 1'b1);
   endtask

   // both paths disabled: frames must pass unmarked
   task automatic t_disabled();
      frame(2, 12, 3, -1, 0);
      frame(0, 12, 3, -1, 0);
   endtask

   // first-nibble trigger, whole-frame hold, no delay
   task automatic t_whole();
      wr(IDX_CTRL, 16'h0033);
      frame(2, 12, 3, 1, 12);
      frame(0, 12, 3, 1, 12);
   endtask

   // delimiter trigger with fixed hold, the 64-cycle hold cut short by frame end
   task automatic t_fixed();
      wr(IDX_CTRL, 16'h0030);
      wr(IDX_CTRL, 16'h000f);
      frame(2, 20, 4, 5, 8);
      frame(0, 20, 4, 5, 8);
      wr(IDX_CTRL, 16'h007f);
      frame(2, 20, 4, 5, 16);
   endtask

   // receive delay per link speed
   task automatic t_rx_delay();
      wr(IDX_RXDEL, 16'h1980);
      frame(2, 40, 4, 11, 30);
      @(posedge clock);
      link_speed_100 <= 1'b0;
      frame(2, 40, 4, 8, 33);
   endtask

   // transmit delay in 8 ns units and the fifo-side tap
   task automatic t_tx_delay();
      wr(IDX_TXDEL, 16'h1470);
      frame(0, 40, 4, 9, 32);
      @(posedge clock);
      link_speed_100 <= 1'b1;
      frame(0, 40, 4, 7, 34);
      @(posedge clock);
      tx_fifo_bypass <= 1'b0;
      frame(0, 40, 4, -1, 0);
      frame(1, 40, 4, 7, 34);
   endtask

   // first-nibble trigger with short delays, except the 100M transmit run which has no delay
   task automatic t_first_delay();
      wr(IDX_CTRL, 16'h007c);
      wr(IDX_CTRL, 16'h0070);
      wr(IDX_CTRL, 16'h0073);
      wr(IDX_RXDEL, 16'h1080);
      wr(IDX_TXDEL, 16'h0500);
      frame(1, 12, 3, 1, 12);
      frame(2, 12, 3, 3, 10);
      @(posedge clock);
      link_speed_100 <= 1'b0;
      tx_fifo_bypass <= 1'b1;
      frame(2, 12, 3, 3, 10);
      frame(0, 12, 3, 2, 11);
   endtask

   task automatic test_done();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (4) @(posedge clock);
      resetn <= 1'b1;
      t_regs();
      t_disabled();
      t_whole();
      t_fixed();
      t_rx_delay();
      t_tx_delay();
      t_first_delay();
      test_done();
   end

   // watchdog well beyond the roughly 1200 cycles the tests need
   initial begin
      #(40 * 20000);
      n_errors++;
      test_done();
   end
endmodule
`default_nettype wire
